// ===== lock_in_pkg.sv
// shared constants for the lock-in reference control block
package lock_in_pkg;

  // ----------------------------------------
  // clock and timing source
  // ----------------------------------------
  localparam longint unsigned CLK_HZ       = 64'd250_000_000;
  localparam longint unsigned FILT_CLK_HZ  = 64'd1_048_576;
  localparam longint unsigned NCO_INC_WIDE = (FILT_CLK_HZ << 32) / CLK_HZ;
  localparam logic [31:0]     NCO_INC      = NCO_INC_WIDE[31:0];
  localparam int              FILT_DIV     = 8;  // 1.048576 MHz down to 131.072 kHz
  localparam int              REF_DIV      = 4;  // sampling/4 gives 32.768 kHz
  localparam logic [31:0]     REF_HZ       = 32'h0000_8000;  // 32.768 kHz
  localparam logic [31:0]     HALF_REF_HZ  = REF_HZ >> 1;    // 16.384 kHz

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] GAIN_OFFSET   = 8'h04;
  localparam logic [7:0] PHASE_OFFSET  = 8'h08;
  localparam logic [7:0] UFREQ_OFFSET  = 8'h0c;
  localparam logic [7:0] SAVE_OFFSET   = 8'h10;
  localparam logic [7:0] STATUS_OFFSET = 8'h14;

  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int CTRL_ON_BIT     = 0;
  localparam int CTRL_PI_BIT     = 1;
  localparam int CTRL_FILTEN_BIT = 2;
  localparam int CTRL_LOCK_BIT   = 3;
  localparam int CTRL_MONERR_BIT = 4;
  localparam int CTRL_DEMOD_LSB  = 5;
  localparam int CTRL_FSEL_LSB   = 8;
  localparam int CTRL_CORNER_LSB = 12;
  localparam int CTRL_WIDTH      = 14;

  // ----------------------------------------
  // reset values and limits
  // ----------------------------------------
  localparam logic [13:0] CTRL_RESET  = 14'h0001;
  localparam logic [6:0]  GAIN_RESET  = 7'h00;
  localparam logic [6:0]  GAIN_MAX_DB = 7'h50;  // 80 dB
  localparam logic [3:0]  DB_PER_SHIFT = 4'h6;
  localparam logic [15:0] PHASE_RESET = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] { DEMOD_OFF, DEMOD_FIRST, DEMOD_SECOND, DEMOD_SPARE } demod_t;
  typedef enum logic [2:0] { FILT_BANDPASS_EIGHTH, FILT_BANDPASS_QUARTER_NARROW,
                             FILT_BANDPASS_QUARTER_WIDE, FILT_LOWPASS_FIFTH,
                             FILT_LOWPASS_EIGHTH, FILT_NOTCH_QUARTER,
                             FILT_ALL_PASS, FILT_SPARE } filter_sel_t;
  typedef enum { PH_IDLE, PH_REPHASE, PH_READY } phase_state_t;

endpackage

// ===== ref_timing_if.sv
// strobes shared between the timing generator and the control logic
`timescale 1ns/10ps
interface ref_timing_if;
  logic filtClkStb;   // 1.048576 MHz filter bank clock strobe
  logic sampleStb;    // 131.072 kHz filter sampling strobe
  logic refPeriodStb; // one per demodulation reference period
  logic refSquare;    // 32.768 kHz demodulation reference
  logic halfSquare;   // 16.384 kHz square for second derivative mode

  modport gen (output filtClkStb, output sampleStb, output refPeriodStb,
               output refSquare, output halfSquare);
  modport use_side (input filtClkStb, input sampleStb, input refPeriodStb,
                    input refSquare, input halfSquare);
endinterface

// ===== ref_timing_gen.sv
// filter clock, sampling and reference strobes from one phase accumulator
`timescale 1ns/10ps
module ref_timing_gen
  import lock_in_pkg::*;
#(
  parameter int FiltDiv = FILT_DIV,
  parameter int RefDiv  = REF_DIV
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  ref_timing_if.gen   tim
);
  logic [31:0]                  ncoAcc_q;
  logic                         ncoCarry;
  logic [$clog2(FiltDiv)-1:0]   filtCnt_q;
  logic [$clog2(RefDiv)-1:0]    refCnt_q;
  logic                         half_q;

  // accumulator carry is the filter clock strobe
  assign ncoCarry = (ncoAcc_q > (ncoAcc_q + NCO_INC));

  // ----------------------------------------
  // accumulator
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ncoAcc_q <= 32'h0000_0000;
    end else begin
      ncoAcc_q <= ncoAcc_q + NCO_INC;
    end
  end

  // ----------------------------------------
  // divider chain, all in one domain so edges keep fixed phase
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filtCnt_q <= '0;
      refCnt_q  <= '0;
      half_q    <= 1'b0;
    end else if (ncoCarry) begin
      filtCnt_q <= filtCnt_q + 1'b1;
      if (filtCnt_q == $bits(filtCnt_q)'(FiltDiv - 1)) begin
        refCnt_q <= refCnt_q + 1'b1;
        if (refCnt_q == $bits(refCnt_q)'(RefDiv - 1)) begin
          half_q <= ~half_q;
        end
      end
    end
  end

  assign tim.filtClkStb   = ncoCarry;
  assign tim.sampleStb    = ncoCarry && (filtCnt_q == $bits(filtCnt_q)'(FiltDiv - 1));
  assign tim.refPeriodStb = tim.sampleStb && (refCnt_q == $bits(refCnt_q)'(RefDiv - 1));
  assign tim.refSquare    = refCnt_q[$bits(refCnt_q)-1];
  assign tim.halfSquare   = half_q;
endmodule // ref_timing_gen

// ===== lock_in_reference_control.sv
// lock-in reference control: registers, rephasing, loop and filter controls
//
// Notes on behaviour
// - demodulation reference runs at fixed 32.768 kHz from the synthesizer timing source
// - first derivative mode forces synthesizer frequency to 32.768 kHz
// - second derivative mode forces synthesizer frequency to 16.384 kHz
// - in either derivative mode the user frequency is ignored and flagged inactive
// - active at power-up: rephase until phase equals stored modulation phase
// - unit is unusable until rephasing finishes
// - demodulation off lifts frequency constraint and skips startup rephasing
// - phase-ready asserts only once rephasing has completed
// - a change into a derivative mode reruns rephasing, ready again within seconds
// - clearing the on bit stops lock-in operation and disables the demodulator
// - loop mode selects proportional or proportional plus integral
// - filter enable inserts or bypasses low-pass, which only smooths in PI mode; separate corner setting
// - lock gates correction to the laser, closing or opening the loop
// - save request stores control and gain settings; they load as defaults at power-on
// - variable gain accepted only from 0 dB to 80 dB inclusive
// - monitor output shows either the loop correction or the error input
// - filter bank clock comes from synthesizer reference at 1.048576 MHz
// - divider chain brings filter clock to 131.072 kHz sampling rate
// - filter selector picks one of seven filter responses
// - low-pass picks are fourth order at sampling/5 and sampling/8
`timescale 1ns/10ps
module lock_in_reference_control
  import lock_in_pkg::*;
#(
  parameter int DataW = 16
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // axi4-lite slave
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // nonvolatile settings store
  input  wire logic [31:0]             nvDefaults,
  output logic                         nvSaveReq,
  output logic [31:0]                  nvSaveData,
  // signal path
  input  wire logic signed [DataW-1:0] errIn,
  output logic signed [DataW-1:0]      laserCorr,
  output logic signed [DataW-1:0]      monitorOut,
  output logic [2:0]                   filterSel,
  output logic                         filterClkStb,
  output logic                         filterSampleStb,
  // synthesizer and reference
  output logic [31:0]                  synthFreq,
  output logic                         synthFreqUserActive,
  output logic [15:0]                  synthPhase,
  output logic                         demodRef,
  output logic                         demodEnable,
  output logic                         phaseReady
);
  ref_timing_if tim ();

  logic [CTRL_WIDTH-1:0]    ctrl_q;
  logic [6:0]               gain_q;
  logic [15:0]              phaseTarget_q;
  logic [31:0]              userFreq_q;
  logic                     loadDone_q;
  logic [7:0]               awAddr_q;
  logic                     awHave_q;
  logic [31:0]              wData_q;
  logic [3:0]               wStrb_q;
  logic                     wHave_q;
  logic                     doWrite;
  logic                     wrHit;
  logic [31:0]              rdData;
  logic                     rdHit;
  logic                     saveReq_q;
  demod_t                   demodMode;
  demod_t                   demodPrev_q;
  phase_state_t             phState_q;
  logic [15:0]              phase_q;
  logic                     unitOn;
  logic [3:0]               gainShift;
  logic signed [DataW+15:0] errScaled;
  logic signed [DataW+15:0] integ_q;
  logic signed [DataW+15:0] loopSum;
  logic signed [DataW+15:0] lp_q;
  logic signed [DataW+15:0] filtered;
  logic signed [DataW-1:0]  corr_q;
  logic signed [DataW-1:0]  mon_q;
  logic [31:0]              synthFreq_q;

  ref_timing_gen #(
    .FiltDiv (FILT_DIV),
    .RefDiv  (REF_DIV)
  ) u_timing (
    .clk   (clk),
    .rst_n (rst_n),
    .tim   (tim.gen)
  );

  assign demodMode = demod_t'(ctrl_q[CTRL_DEMOD_LSB +: 2]);
  assign unitOn    = ctrl_q[CTRL_ON_BIT];

  // ----------------------------------------
  // axi4-lite write side
  // ----------------------------------------
  // address and data may come in either order; each is held until both are here
  assign s_axi_awready = !awHave_q;
  assign s_axi_wready  = !wHave_q;
  assign doWrite       = awHave_q && wHave_q && !s_axi_bvalid;
  assign wrHit         = (awAddr_q == CTRL_OFFSET) || (awAddr_q == GAIN_OFFSET)
                      || (awAddr_q == PHASE_OFFSET) || (awAddr_q == UFREQ_OFFSET)
                      || (awAddr_q == SAVE_OFFSET) || (awAddr_q == STATUS_OFFSET);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHave_q     <= 1'b0;
      awAddr_q     <= 8'h00;
      wHave_q      <= 1'b0;
      wData_q      <= 32'h0000_0000;
      wStrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_q     <= 1'b0;
        wHave_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // settings registers
  // ----------------------------------------
  // defaults come from the store one cycle after reset release, never under reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q        <= CTRL_RESET;
      gain_q        <= GAIN_RESET;
      loadDone_q    <= 1'b0;
    end else if (!loadDone_q) begin
      loadDone_q <= 1'b1;
      ctrl_q     <= nvDefaults[CTRL_WIDTH-1:0];
      if (nvDefaults[22:16] <= GAIN_MAX_DB) begin
        gain_q <= nvDefaults[22:16];
      end
    end else if (doWrite) begin
      if (awAddr_q == CTRL_OFFSET && wStrb_q[0]) begin
        ctrl_q[7:0] <= wData_q[7:0];
      end
      if (awAddr_q == CTRL_OFFSET && wStrb_q[1]) begin
        ctrl_q[CTRL_WIDTH-1:8] <= wData_q[CTRL_WIDTH-1:8];
      end
      // out-of-range gain leaves the old setting in place
      if (awAddr_q == GAIN_OFFSET && wStrb_q[0] && wData_q[7:0] <= {1'b0, GAIN_MAX_DB}) begin
        gain_q <= wData_q[6:0];
      end
    end
  end

  // phase target and user frequency
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseTarget_q <= PHASE_RESET;
      userFreq_q    <= 32'h0000_0000;
    end else if (doWrite) begin
      if (awAddr_q == PHASE_OFFSET && wStrb_q[0]) phaseTarget_q[7:0]  <= wData_q[7:0];
      if (awAddr_q == PHASE_OFFSET && wStrb_q[1]) phaseTarget_q[15:8] <= wData_q[15:8];
      if (awAddr_q == UFREQ_OFFSET) begin
        for (int b = 0; b < 4; b++) begin
          if (wStrb_q[b]) userFreq_q[8*b +: 8] <= wData_q[8*b +: 8];
        end
      end
    end
  end

  // save pulse carries the current control and gain settings to the store
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      saveReq_q  <= 1'b0;
      nvSaveData <= 32'h0000_0000;
    end else begin
      saveReq_q <= doWrite && (awAddr_q == SAVE_OFFSET) && wStrb_q[0] && wData_q[0];
      if (doWrite && (awAddr_q == SAVE_OFFSET)) begin
        nvSaveData <= {9'h000, gain_q, 2'b00, ctrl_q};
      end
    end
  end
  assign nvSaveReq = saveReq_q;

  // ----------------------------------------
  // axi4-lite read side
  // ----------------------------------------
  always_comb begin
    rdHit  = 1'b1;
    rdData = 32'h0000_0000;
    case ({s_axi_araddr[7:2], 2'b00})
      CTRL_OFFSET:   rdData = {{(32-CTRL_WIDTH){1'b0}}, ctrl_q};
      GAIN_OFFSET:   rdData = {25'h0000000, gain_q};
      PHASE_OFFSET:  rdData = {16'h0000, phaseTarget_q};
      UFREQ_OFFSET:  rdData = userFreq_q;
      SAVE_OFFSET:   rdData = 32'h0000_0000;
      STATUS_OFFSET: rdData = {phase_q, 12'h000, synthFreqUserActive,
                               demodEnable, (phState_q == PH_REPHASE), phaseReady};
      default:       rdHit  = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdData;
      s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // rephasing sequence
  // ----------------------------------------
  // one phase step per reference period: a full turn takes two seconds at most
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phState_q   <= PH_IDLE;
      phase_q     <= PHASE_RESET;
      demodPrev_q <= DEMOD_OFF;
    end else begin
      demodPrev_q <= demodMode;
      // the spare mode code is handled as off, so it never starts a rephase
      if (!loadDone_q || !unitOn || demodMode == DEMOD_OFF || demodMode == DEMOD_SPARE) begin
        phState_q <= PH_IDLE;
      end else if (demodMode != demodPrev_q || phState_q == PH_IDLE) begin
        phState_q <= PH_REPHASE;
      end else begin
        case (phState_q)
          PH_REPHASE: begin
            if (phase_q == phaseTarget_q) begin
              phState_q <= PH_READY;
            end else if (tim.refPeriodStb) begin
              phase_q <= (phaseTarget_q > phase_q) ? phase_q + 16'h0001 : phase_q - 16'h0001;
            end
          end
          PH_READY: begin
            if (phase_q != phaseTarget_q) phState_q <= PH_REPHASE;
          end
          default: phState_q <= PH_IDLE;
        endcase
      end
    end
  end

  assign phaseReady  = (phState_q == PH_READY);
  assign demodEnable = (phState_q == PH_READY);
  assign synthPhase  = phase_q;
  assign demodRef    = unitOn && tim.refSquare;

  // ----------------------------------------
  // synthesizer frequency override
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      synthFreq_q <= 32'h0000_0000;
    end else begin
      case (demodMode)
        DEMOD_FIRST:  synthFreq_q <= REF_HZ;
        DEMOD_SECOND: synthFreq_q <= HALF_REF_HZ;
        default:      synthFreq_q <= userFreq_q;
      endcase
    end
  end
  assign synthFreq           = synthFreq_q;
  assign synthFreqUserActive = (demodMode == DEMOD_OFF) || (demodMode == DEMOD_SPARE);

  // ----------------------------------------
  // correction loop, updated on each filter sample
  // ----------------------------------------
  // gain as a power-of-two shift: about 6 dB per bit, coarse but cheap
  assign gainShift = 4'(gain_q / {3'h0, DB_PER_SHIFT});
  assign errScaled = (DataW+16)'(errIn) <<< gainShift;
  assign loopSum   = ctrl_q[CTRL_PI_BIT] ? errScaled + integ_q : errScaled;
  assign filtered  = ctrl_q[CTRL_FILTEN_BIT] ? lp_q : loopSum;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      integ_q <= '0;
      lp_q    <= '0;
    end else if (!demodEnable || !ctrl_q[CTRL_PI_BIT]) begin
      integ_q <= '0;
      lp_q    <= loopSum;
    end else if (tim.sampleStb) begin
      integ_q <= integ_q + (errScaled >>> 8);
      // corner setting picks the smoothing shift
      lp_q    <= lp_q + ((loopSum - lp_q) >>> (ctrl_q[CTRL_CORNER_LSB +: 2] + 2'd1));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      corr_q <= '0;
      mon_q  <= '0;
    end else if (tim.sampleStb || !demodEnable) begin
      corr_q <= (demodEnable && ctrl_q[CTRL_LOCK_BIT]) ? filtered[DataW-1:0] : '0;
      mon_q  <= ctrl_q[CTRL_MONERR_BIT] ? errIn : filtered[DataW-1:0];
    end
  end
  assign laserCorr  = corr_q;
  assign monitorOut = mon_q;

  // filter bank controls
  assign filterSel       = ctrl_q[CTRL_FSEL_LSB +: 3];
  assign filterClkStb    = tim.filtClkStb;
  assign filterSampleStb = tim.sampleStb;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_first_freq;
    @(posedge clk) disable iff (!rst_n) demodMode == DEMOD_FIRST |=> synthFreq == REF_HZ;
  endproperty
  a_first_freq: assert property (p_first_freq) else $error("first mode freq wrong");

  property p_second_freq;
    @(posedge clk) disable iff (!rst_n) demodMode == DEMOD_SECOND |=> synthFreq == HALF_REF_HZ;
  endproperty
  a_second_freq: assert property (p_second_freq) else $error("second mode freq wrong");

  property p_user_inactive;
    @(posedge clk) disable iff (!rst_n)
      (demodMode == DEMOD_FIRST || demodMode == DEMOD_SECOND) |-> !synthFreqUserActive;
  endproperty
  a_user_inactive: assert property (p_user_inactive) else $error("user freq active");

  property p_ready_match;
    @(posedge clk) disable iff (!rst_n) $rose(phaseReady) |-> $past(phase_q) == phaseTarget_q;
  endproperty
  a_ready_match: assert property (p_ready_match) else $error("ready before phase match");

  property p_mode_change_clears;
    @(posedge clk) disable iff (!rst_n)
      (loadDone_q && unitOn && demodMode != DEMOD_OFF && demodMode != demodPrev_q)
        |=> !phaseReady;
  endproperty
  a_mode_change_clears: assert property (p_mode_change_clears) else $error("ready kept");

  property p_off_no_demod;
    @(posedge clk) disable iff (!rst_n) !unitOn |=> !demodEnable ##1 laserCorr == '0;
  endproperty
  a_off_no_demod: assert property (p_off_no_demod) else $error("demod on while off");

  property p_unlock_zero;
    @(posedge clk) disable iff (!rst_n)
      (!ctrl_q[CTRL_LOCK_BIT] && tim.sampleStb) |=> laserCorr == '0;
  endproperty
  a_unlock_zero: assert property (p_unlock_zero) else $error("correction while open");

  property p_gain_range;
    @(posedge clk) disable iff (!rst_n) gain_q <= GAIN_MAX_DB;
  endproperty
  a_gain_range: assert property (p_gain_range) else $error("gain above 80 dB");

  property p_save_pulse;
    @(posedge clk) disable iff (!rst_n) nvSaveReq |=> !nvSaveReq;
  endproperty
  a_save_pulse: assert property (p_save_pulse) else $error("save held");

  property p_ref_period;
    @(posedge clk) disable iff (!rst_n) tim.refPeriodStb |-> tim.sampleStb && tim.filtClkStb;
  endproperty
  a_ref_period: assert property (p_ref_period) else $error("ref edge off grid");
endmodule // lock_in_reference_control

// ===== photodet_model.sv
// photodetector and laser correction path stand-in for the lock-in bench
`timescale 1ns/10ps
module photodet_model #(
  parameter logic signed [15:0] ErrLevel = 16'sh0123
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               filterSampleStb,
  input  wire logic signed [15:0] laserCorr,
  output logic signed [15:0]      errIn
);
  // error level changes only on a sample, as a sampled detector would
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) errIn <= 16'sh0000;
    else if (filterSampleStb) errIn <= ErrLevel;
  end
endmodule // photodet_model

// ===== tb_top.sv
// self-checking bench for the lock-in reference control block
`timescale 1ns/10ps
module tb_top;
  import lock_in_pkg::*;
  logic clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, nvSaveReq, filterClkStb, filterSampleStb;
  logic synthFreqUserActive, demodRef, demodEnable, phaseReady;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] filterSel;
  logic [15:0] synthPhase;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, nvDefaults = 32'h0000_0005, nvSaveData, synthFreq, rd;
  logic signed [15:0] errIn, laserCorr, monitorOut;
  int err_total = 0, check_count = 0, cyc = 0, n;
  lock_in_reference_control lock_in_reference_control_i (.*);
  photodet_model photodet_model_i (.*);
  // ----------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------
  always #2 clk = ~clk;
  // ceiling sits well above two rephase waits plus register traffic
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end
  task automatic end_sim;
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic wait_stb;
    do @(posedge clk); while (filterSampleStb !== 1'b1);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_rephase;
    chk("userActive off", synthFreqUserActive, 1);
    chk("ready off", phaseReady, 0);
    rdr(CTRL_OFFSET);
    chk("ctrl default", rd, 32'h0000_0005);
    wr(PHASE_OFFSET, 32'h0000_0001);
    wr(UFREQ_OFFSET, 32'h0000_04d2);
    // synthesizer word is registered after the setting, so let one edge pass
    @(posedge clk);
    chk("user freq", synthFreq, 32'h0000_04d2);
    wr(CTRL_OFFSET, 32'h0000_0021);
    @(posedge clk);
    chk("ready cleared", phaseReady, 0);
    chk("first freq", synthFreq, REF_HZ);
    chk("userActive first", synthFreqUserActive, 0);
    chk("corr not ready", laserCorr, 0);
    repeat (20000) if (phaseReady !== 1'b1) @(posedge clk);
    chk("ready first", phaseReady, 1);
    chk("phase", synthPhase, 16'h0001);
    wr(CTRL_OFFSET, 32'h0000_0041);
    @(posedge clk);
    chk("ready dropped", phaseReady, 0);
    chk("second freq", synthFreq, HALF_REF_HZ);
    repeat (20000) if (phaseReady !== 1'b1) @(posedge clk);
    chk("ready second", phaseReady, 1);
    chk("demod on", demodEnable, 1);
    // close the loop in proportional mode at 0 dB: correction follows the error
    wr(CTRL_OFFSET, 32'h0000_0049);
    wait_stb;
    wait_stb;
    chk("corr locked", laserCorr, 16'h0123);
    chk("monitor lock", monitorOut, 16'h0123);
    wr(CTRL_OFFSET, 32'h0000_0040);
    repeat (3) @(posedge clk);
    chk("demod off", demodEnable, 0);
    chk("corr off", laserCorr, 0);
  endtask
  task automatic t_regs;
    wr(GAIN_OFFSET, 32'h0000_0051);
    rdr(GAIN_OFFSET);
    chk("gain 81", rd, 32'h0000_0000);
    wr(GAIN_OFFSET, 32'h0000_0050);
    rdr(GAIN_OFFSET);
    chk("gain 80", rd, 32'h0000_0050);
    wr(8'h18, 32'h0000_0001);
    chk("bad write", rsp, RESP_SLVERR);
    rdr(8'h18);
    chk("bad read", rsp, RESP_SLVERR);
    for (int i = 0; i < 7; i++) begin
      wr(CTRL_OFFSET, 32'h0000_0001 | (i << 8));
      chk("filter sel", filterSel, i);
    end
    wr(CTRL_OFFSET, 32'h0000_0315);
    wr(SAVE_OFFSET, 32'h0000_0001);
    n = 0;
    while (nvSaveReq !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk("save req", nvSaveReq, 1);
    chk("save data", nvSaveData, 32'h0050_0315);
    wait_stb;
    wait_stb;
    chk("monitor err", monitorOut, 16'h0123);
  endtask
  // sample period and filter clocks per sample, both from the one clock
  task automatic t_strobes;
    wait_stb;
    n = 0;
    rd = 0;
    do begin
      @(posedge clk);
      n++;
      if (filterClkStb === 1'b1) rd++;
    end while (filterSampleStb !== 1'b1);
    chk("clk per sample", rd, 8);
    chk("sample period", n >= 1906 && n <= 1909, 1);
    // one full reference period, rise to rise
    while (demodRef !== 1'b0) @(posedge clk);
    while (demodRef !== 1'b1) @(posedge clk);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (demodRef !== 1'b0);
    do begin
      @(posedge clk);
      n++;
    end while (demodRef !== 1'b1);
    chk("ref period", n >= 7628 && n <= 7631, 1);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    t_rephase;
    t_regs;
    t_strobes;
    end_sim;
  end
endmodule // tb_top
